// [rtl/eeprom_pkg.sv]
/*
 * Shared constants and state types of the two-wire serial EEPROM slave.
 * Assumes a 25 MHz system clock and a bus master that owns the serial clock.
 */
package eeprom_pkg;

    // Array organisation
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int PAGE_BYTES = 8;
    localparam int PAGE_W = 5;

    // Device address word layout
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_SEL_LSB = 1;
    localparam int DEV_RW_BIT = 0;

    // Upper half of the array is the protected region
    localparam int PROT_ADDR_BIT = 7;

    // Self-timed programming: time as printed, then in clock cycles
    localparam int INTERNAL_PROGRAM_TIME_MS = 5;
    localparam int CLK_HZ = 25_000_000;
    localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 17;

    // Link side byte sequencer
    typedef enum logic [3:0] {
        L_IDLE, L_DEV, L_DEV_ACK, L_WADDR, L_WADDR_ACK,
        L_WDATA, L_WDATA_ACK, L_RDATA, L_RACK
    } link_state_t;

    // System side programming sequencer
    typedef enum logic [1:0] {
        C_IDLE, C_PROG, C_WAIT
    } commit_state_t;

endpackage : eeprom_pkg

// [rtl/eeprom_array.sv]
/*
 * Storage cells of the EEPROM: write port on the system clock,
 * registered read port on the serial clock.
 * Assumes the caller never reads a cell while it is being programmed.
 */
`timescale 1ns/100ps
module eeprom_array import eeprom_pkg::*; (
    // Write port, system clock
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // Read port, serial clock
    input wire logic rd_clk,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] cells [MEM_DEPTH];

    // Programming of one byte
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    // Registered fetch for the serial shifter
    always_ff @(posedge rd_clk) begin
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end

endmodule : eeprom_array

// [rtl/two_wire_eeprom_slave.sv]
/*
 * Two-wire serial EEPROM slave: byte sequencer on the serial clock,
 * stop detection and self-timed page programming on the system clock.
 * Assumes an open-drain bus resolved outside, with the master driving the
 * serial clock and a few serial clocks with data high during reset.
 */
// Functional notes
// - Array of 256 bytes on serial link
// - 32 pages, eight bytes each
// - One word address byte precedes data
// - Sample on clock rise, drive after fall
// - Data line only pulled low or released
// - Three select inputs pick our address
// - Protect low: whole array writable
// - Protect high: upper half never altered
// - Partial page updates only received bytes
// - Programming finishes within five milliseconds
// - Address word: type, select, direction
// - Acknowledge matched address, word address and data bytes, ninth clock
// - Page write wraps within the page
// - No address acknowledge while programming
`timescale 1ns/100ps
module two_wire_eeprom_slave import eeprom_pkg::*; #(
    parameter int PROG_CYCLES = INTERNAL_PROGRAM_CYCLES
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Two-wire link
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps
    input wire logic [2:0] device_select_inputs,
    input wire logic write_protect,
    // Status
    output logic prog_busy
);

    typedef struct packed {
        link_state_t state;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic read_mode;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_W-1:0] page;
        logic [PAGE_BYTES-1:0] mask;
        logic [PAGE_BYTES-1:0][DATA_W-1:0] page_data;
        logic wr_pend;
        logic sda_rise;
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic [2:0] sel_s3;
        logic [2:0] sel_st;
        logic busy_s1;
        logic busy_s2;
    } link_t;

    typedef struct packed {
        logic start;
        logic oe;
        logic low;
    } drive_t;

    typedef struct packed {
        commit_state_t state;
        logic scl_s1, scl_s2, scl_s3, scl_st;
        logic sda_s1, sda_s2, sda_s3, sda_st;
        logic wp_s1, wp_s2, wp_s3, wp_st;
        logic pend_s1, pend_s2;
        logic free;
        logic prot;
        logic [2:0] idx;
        logic [TIMER_W-1:0] timer;
        logic busy;
        logic [PAGE_BYTES-1:0] mask;
        logic [PAGE_W-1:0] page;
        logic [PAGE_BYTES-1:0][DATA_W-1:0] page_data;
    } commit_t;

    link_t l_reg, l_next;
    drive_t d_reg, d_next;
    commit_t c_reg, c_next;
    logic [1:0] rst_l_reg;
    logic link_rst;
    logic [7:0] rx;
    logic rd_en;
    logic [DATA_W-1:0] rd_data;
    logic stop;
    logic wr_en;

    // Reset carried into the serial clock domain
    always_ff @(posedge scl_clk) begin
        rst_l_reg <= {rst_l_reg[0], reset};
    end
    assign link_rst = rst_l_reg[1];

    eeprom_array u_array (
        .wr_clk (clk),
        .wr_en (wr_en),
        .wr_addr ({c_reg.page, c_reg.idx}),
        .wr_data (c_reg.page_data[c_reg.idx]),
        .rd_clk (scl_clk),
        .rd_en (rd_en),
        .rd_addr (l_reg.addr),
        .rd_data (rd_data)
    );

    // Byte sequencer, sampling on the rising serial clock
    always_comb begin
        l_next = l_reg;
        rd_en = 1'b0;
        rx = {l_reg.shift[6:0], sda_in};
        l_next.sda_rise = sda_in;
        l_next.sel_s1 = device_select_inputs;
        l_next.sel_s2 = l_reg.sel_s1;
        l_next.sel_s3 = l_reg.sel_s2;
        if (l_reg.sel_s2 == l_reg.sel_s3) begin
            l_next.sel_st = l_reg.sel_s3;
        end
        l_next.busy_s1 = c_reg.busy;
        l_next.busy_s2 = l_reg.busy_s1;
        if (d_reg.start) begin
            // Start drops any byte or unfinished page in progress
            l_next.state = L_DEV;
            l_next.bit_cnt = 3'd1;
            l_next.shift = rx;
            l_next.mask = '0;
            l_next.wr_pend = 1'b0;
        end else begin
            case (l_reg.state)
                L_DEV, L_WADDR, L_WDATA: begin
                    l_next.shift = rx;
                    l_next.bit_cnt = l_reg.bit_cnt + 3'd1;
                    if (l_reg.bit_cnt == 3'd7) begin
                        if (l_reg.state == L_DEV) begin
                            // Match type and straps, refuse while programming
                            if (rx[7:DEV_TYPE_LSB] == DEV_TYPE
                                && rx[DEV_SEL_LSB +: 3] == l_reg.sel_st
                                && !l_reg.busy_s2) begin
                                l_next.state = L_DEV_ACK;
                                l_next.read_mode = rx[DEV_RW_BIT];
                            end else begin
                                l_next.state = L_IDLE;
                            end
                        end else if (l_reg.state == L_WADDR) begin
                            l_next.addr = rx;
                            l_next.state = L_WADDR_ACK;
                        end else begin
                            // Stage byte; only the low three bits advance
                            l_next.page_data[l_reg.addr[2:0]] = rx;
                            l_next.mask[l_reg.addr[2:0]] = 1'b1;
                            l_next.page = l_reg.addr[7:3];
                            l_next.wr_pend = 1'b1;
                            l_next.addr[2:0] = l_reg.addr[2:0] + 3'd1;
                            l_next.state = L_WDATA_ACK;
                        end
                    end
                end
                L_DEV_ACK: begin
                    l_next.bit_cnt = 3'd0;
                    rd_en = l_reg.read_mode;
                    l_next.state = l_reg.read_mode ? L_RDATA : L_WADDR;
                end
                L_WADDR_ACK, L_WDATA_ACK: begin
                    l_next.bit_cnt = 3'd0;
                    l_next.state = L_WDATA;
                end
                L_RDATA: begin
                    l_next.bit_cnt = l_reg.bit_cnt + 3'd1;
                    if (l_reg.bit_cnt == 3'd7) begin
                        l_next.addr = l_reg.addr + 8'h01;
                        l_next.state = L_RACK;
                    end
                end
                L_RACK: begin
                    // Master acknowledge asks for the next byte
                    rd_en = !sda_in;
                    l_next.state = sda_in ? L_IDLE : L_RDATA;
                end
                default: begin
                    l_next.state = L_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // Line driver and start detection, on the falling serial clock
    always_comb begin
        d_next = '0;
        // After a stop the clock stays high, so no rising edge saw the data
        // line high; the quiet bus level from the system side stands in.
        // It is set long before the start and is clear again by the second
        // falling edge, so reading it here without flops is safe.
        d_next.start = (l_reg.sda_rise || c_reg.free) && !sda_in;
        if (!d_next.start) begin
            case (l_reg.state)
                L_DEV_ACK, L_WADDR_ACK, L_WDATA_ACK: d_next.oe = 1'b1;
                L_RDATA: d_next.oe = !rd_data[3'd7 - l_reg.bit_cnt];
                default: d_next.oe = 1'b0;
            endcase
        end
    end

    // Output only ever pulls low
    always_ff @(negedge scl_clk) begin
        if (link_rst) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    // Pin synchronisers, stop detection and self-timed programming
    always_comb begin
        c_next = c_reg;
        wr_en = 1'b0;
        c_next.scl_s1 = scl_clk;
        c_next.scl_s2 = c_reg.scl_s1;
        c_next.scl_s3 = c_reg.scl_s2;
        c_next.sda_s1 = sda_in;
        c_next.sda_s2 = c_reg.sda_s1;
        c_next.sda_s3 = c_reg.sda_s2;
        c_next.wp_s1 = write_protect;
        c_next.wp_s2 = c_reg.wp_s1;
        c_next.wp_s3 = c_reg.wp_s2;
        c_next.pend_s1 = l_reg.wr_pend;
        c_next.pend_s2 = c_reg.pend_s1;
        if (c_reg.scl_s2 == c_reg.scl_s3) begin
            c_next.scl_st = c_reg.scl_s3;
        end
        if (c_reg.sda_s2 == c_reg.sda_s3) begin
            c_next.sda_st = c_reg.sda_s3;
        end
        if (c_reg.wp_s2 == c_reg.wp_s3) begin
            c_next.wp_st = c_reg.wp_s3;
        end
        stop = c_reg.scl_st && c_reg.scl_s2 && c_reg.scl_s3 && !c_reg.sda_st
            && c_next.sda_st;
        // Bus free from a stop until the serial clock falls again
        if (stop) begin
            c_next.free = 1'b1;
        end else if (!c_reg.scl_s2) begin
            c_next.free = 1'b0;
        end
        case (c_reg.state)
            C_IDLE: begin
                // Staged page is quiet once the link has stopped
                if (stop && c_reg.pend_s2) begin
                    c_next.state = C_PROG;
                    c_next.mask = l_reg.mask;
                    c_next.page = l_reg.page;
                    c_next.page_data = l_reg.page_data;
                    c_next.prot = c_reg.wp_st;
                    c_next.idx = 3'd0;
                    c_next.timer = '0;
                end
            end
            C_PROG: begin
                wr_en = c_reg.mask[c_reg.idx]
                    && !(c_reg.prot && c_reg.page[PAGE_W-1]);
                c_next.timer = c_reg.timer + 1'b1;
                c_next.idx = c_reg.idx + 3'd1;
                if (c_reg.idx == 3'd7) begin
                    c_next.state = C_WAIT;
                end
            end
            C_WAIT: begin
                c_next.timer = c_reg.timer + 1'b1;
                if (c_reg.timer == TIMER_W'(PROG_CYCLES - 1)) begin
                    c_next.state = C_IDLE;
                end
            end
            default: begin
                c_next.state = C_IDLE;
            end
        endcase
        c_next.busy = (c_next.state != C_IDLE);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    assign sda_out = d_reg.low;
    assign sda_oe = d_reg.oe;
    assign prog_busy = c_reg.busy;

    // Checks on the serial side
    AST_ACK_LOW: assert property (@(posedge scl_clk) disable iff (link_rst)
        (l_reg.state inside {L_WADDR_ACK, L_WDATA_ACK} && !d_reg.start) |-> d_reg.oe)
        else $error("received byte not acknowledged");
    AST_SELECT_MATCH: assert property (@(posedge scl_clk) disable iff (link_rst)
        $rose(l_reg.state == L_DEV_ACK) |-> l_reg.shift[7:4] == DEV_TYPE
            && l_reg.shift[3:1] == l_reg.sel_st)
        else $error("acknowledged a foreign device address");
    AST_BUSY_NACK: assert property (@(posedge scl_clk) disable iff (link_rst)
        (l_reg.state == L_DEV && l_reg.bit_cnt == 3'd7 && l_reg.busy_s2 && !d_reg.start)
            |=> l_reg.state == L_IDLE)
        else $error("address acknowledged while programming");
    AST_PAGE_WRAP: assert property (@(posedge scl_clk) disable iff (link_rst)
        (l_reg.state == L_WDATA && l_reg.bit_cnt == 3'd7 && !d_reg.start)
            |=> l_reg.addr[7:3] == $past(l_reg.addr[7:3])
            && l_reg.addr[2:0] == 3'($past(l_reg.addr[2:0]) + 3'd1))
        else $error("page write address left its page");
    AST_START_ABORT: assert property (@(posedge scl_clk) disable iff (link_rst)
        d_reg.start |=> l_reg.state == L_DEV && l_reg.bit_cnt == 3'd1 && l_reg.mask == '0)
        else $error("start did not restart the sequencer");

    // Checks on the programming side
    AST_DRAIN_ONLY: assert property (@(posedge clk) disable iff (reset)
        !sda_out)
        else $error("data line driven high");
    AST_PROTECT: assert property (@(posedge clk) disable iff (reset)
        wr_en |-> !(c_reg.prot && c_reg.page[PAGE_W-1]))
        else $error("protected half programmed");
    AST_ONLY_RECEIVED: assert property (@(posedge clk) disable iff (reset)
        wr_en |-> c_reg.mask[c_reg.idx] && c_reg.state == C_PROG)
        else $error("byte programmed that was never received");
    AST_PROG_END: assert property (@(posedge clk) disable iff (reset)
        (c_reg.state == C_WAIT && c_reg.timer == TIMER_W'(PROG_CYCLES - 1)) |=> !prog_busy)
        else $error("programming overran its time");

endmodule : two_wire_eeprom_slave

// [sim/wire_master.sv]
/* Two-wire bus master model: makes the serial clock and pulls the data wire low.
   Assumes the bench resolves the wire with a pull-up and the device's pull-down. */
`timescale 1ns/100ps
module wire_master (
    // Wire
    output logic scl_clk,
    output logic pull_low,
    input wire logic sda
);
    // Clock stands high and data released outside frames
    initial begin
        scl_clk = 1'b1;
        pull_low = 1'b0;
    end
    // Free pulses with data released, no frame
    task automatic pulses(input int n);
        repeat (n) begin
            #80 scl_clk = 1'b0;
            #80 scl_clk = 1'b1;
        end
    endtask : pulses
    // Data falls while clock high, then clock low
    task automatic start();
        #40 pull_low = 1'b0;
        #40 scl_clk = 1'b1;
        #40 pull_low = 1'b1;
        #40 scl_clk = 1'b0;
    endtask : start
    // Data rises while clock high, then bus free
    task automatic stop();
        #40 pull_low = 1'b1;
        #40 scl_clk = 1'b1;
        #40 pull_low = 1'b0;
        #600;
    endtask : stop
    // One bit: data moved mid low, sampled mid high
    task automatic bit_io(input logic b, output logic r);
        #40 pull_low = ~b;
        #40 scl_clk = 1'b1;
        #40 r = sda;
        #40 scl_clk = 1'b0;
    endtask : bit_io
    // Byte out MSB first, device answer in the ninth bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send_byte
    // Byte in MSB first, master acknowledge when more wanted
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask : recv_byte
endmodule : wire_master

// [sim/two_wire_eeprom_slave_bench.sv]
/* Self-checking bench of the two-wire EEPROM slave against a master model.
   Assumes the master model owns the serial clock; the wire has a pull-up. */
`timescale 1ns/100ps
module two_wire_eeprom_slave_bench import eeprom_pkg::*; ();
    localparam int PROG = 100;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [7:0] DEV_W = {DEV_TYPE, SEL, 1'b0};
    logic clk, reset, scl_clk, sda_in, sda_out, sda_oe, write_protect, prog_busy, pull_low;
    logic [2:0] device_select_inputs;
    logic [7:0] exp_mem [256];
    logic [31:0] busy_len = '0;
    logic [31:0] last_len = '0;
    int miscompares = 0;
    int n_checks = 0;

    // Open-drain wire with pull-up
    assign sda_in = ~(pull_low | sda_oe);

    two_wire_eeprom_slave #(.PROG_CYCLES(PROG)) u_two_wire_eeprom_slave (
        .clk(clk), .reset(reset), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .device_select_inputs(device_select_inputs),
        .write_protect(write_protect), .prog_busy(prog_busy)
    );
    wire_master u_wire_master (.scl_clk(scl_clk), .pull_low(pull_low), .sda(sda_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Length of the last busy stretch
    always @(posedge clk) begin
        if (prog_busy) busy_len <= busy_len + 32'h1;
        else busy_len <= '0;
        if (!prog_busy && busy_len != '0) last_len <= busy_len;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Wire watch: device moves data only with clock low, only ever pulls low
    always @(sda_oe) if (reset === 1'b0) check(scl_clk, 1'b0);
    always @(posedge scl_clk) if (sda_oe) check(sda_out, 1'b0);

    // Address word alone, then stop
    task automatic probe(input logic [7:0] dev, input logic want);
        logic ack;
        u_wire_master.start();
        u_wire_master.send_byte(dev, ack);
        check(ack, want);
        u_wire_master.stop();
    endtask : probe

    // Write n bytes from word address a, poll, time programming
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v);
        logic ack;
        logic [7:0] p;
        u_wire_master.start();
        u_wire_master.send_byte(DEV_W, ack);
        check(ack, 1'b1);
        u_wire_master.send_byte(a, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            p = {a[7:3], a[2:0] + 3'(i)};
            u_wire_master.send_byte(v + 8'(i), ack);
            check(ack, 1'b1);
            if (!(write_protect && a[7])) exp_mem[p] = v + 8'(i);
        end
        u_wire_master.stop();
        check(prog_busy, 1'b1);
        probe(DEV_W, 1'b0);
        for (int i = 0; i < 1000 && prog_busy !== 1'b0; i++) @(negedge clk);
        if (prog_busy !== 1'b0) begin
            miscompares++;
            close_out();
        end
        repeat (2) @(negedge clk);
        check(last_len, PROG);
        probe(DEV_W, 1'b1);
    endtask : wr

    // Random read of n bytes from a, sequential after the first
    task automatic rd(input logic [7:0] a, input int n);
        logic ack;
        logic [7:0] d;
        u_wire_master.start();
        u_wire_master.send_byte(DEV_W, ack);
        check(ack, 1'b1);
        u_wire_master.send_byte(a, ack);
        check(ack, 1'b1);
        u_wire_master.start();
        u_wire_master.send_byte(DEV_W | 8'h01, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_wire_master.recv_byte(i < n - 1, d);
            check(d, exp_mem[a + 8'(i)]);
        end
        u_wire_master.stop();
    endtask : rd

    // Only our own select code and type are answered
    task automatic t_select();
        for (int s = 0; s < 8; s++) probe({DEV_TYPE, 3'(s), 1'b0}, 3'(s) == SEL);
        probe({4'hb, SEL, 1'b0}, 1'b0);
    endtask : t_select

    // Full page, wrapping page, partial page
    task automatic t_page();
        wr(8'h10, 1, 8'h3c);
        rd(8'h10, 1);
        wr(8'h40, 8, 8'h00);
        wr(8'h45, 10, 8'ha0);
        wr(8'h42, 2, 8'h70);
        rd(8'h40, 8);
    endtask : t_page

    // Upper half locked while protect high; lower half and reads free
    task automatic t_protect();
        wr(8'hf8, 8, 8'h11);
        wr(8'h00, 8, 8'hc0);
        @(negedge clk) write_protect = 1'b1;
        wr(8'hf8, 8, 8'h99);
        wr(8'h78, 8, 8'h55);
        rd(8'hf8, 16);
        rd(8'h78, 8);
        @(negedge clk) write_protect = 1'b0;
    endtask : t_protect

    // Reset with idle serial pulses, then scenarios
    initial begin
        reset = 1'b1;
        device_select_inputs = SEL;
        write_protect = 1'b0;
        u_wire_master.pulses(4);
        @(negedge clk) reset = 1'b0;
        u_wire_master.pulses(3);
        t_select();
        t_page();
        t_protect();
        close_out();
    end
endmodule : two_wire_eeprom_slave_bench
